// ### verilog/glue_logic_unit.sv
// glue logic unit: two truth tables, filters, sequential element, apb
`timescale 1ns/100ps
// Notes on behaviour
// - sequential select writable only while even table off
// - table control bits locked while that table enabled
// - enabling write accepts locked bits; disabling write not
// - global and per-table enable bits switch on/off
// - output is truth bit indexed by inputs
// - three inputs, each with own source select
// - feedback source carries the sequential output
// - linked source carries next table's direct output
// - two event lines selectable; software routes them first
// - synchronizer or filter delays two to five cycles
// - filter and edge state cleared one cycle after disable
// - edge detector pulses on rising edge
// - sequential element fed from filtered/edge table outputs
// - flip-flop modes clocked by even table's clock; latch modes are not
// - even table disable clears sequential element
// - gated flip-flop: gate high loads data on edge
// - jk flip-flop: hold, clear, set, toggle
// - gated latch follows data while gate high
// - rs latch: set, clear, hold; both high forbidden
// - input 2 clock select: clocks table, masks input 2
// - table outputs offered as events; events usable inputs
// - sequential select encodings zero to four
// - filter select encodings none, sync, filter
module glue_logic_unit #(
	parameter int ADDR_W = glue_logic_pkg::APB_ADDR_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// input sources: pins are table*3+input, events asynchronous
	input wire logic [5:0] table_pin_in,
	input wire logic event_input_a,
	input wire logic event_input_b,
	input wire logic comparator_out,
	input wire logic [2:0] timer_wave,
	// outputs, one bit per table
	output logic [1:0] table_output,
	output logic [1:0] table_output_event,
	output logic [1:0] table_pin_out,
	output logic [1:0] table_pin_drive
);
	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (ADDR_W < glue_logic_pkg::APB_ADDR_W) begin : g_chk
		$error("address width too small for the register map");
	end

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic global_en; // whole unit on
	logic run_in_standby; // stored only, no sleep logic here
	logic [3:0] seq_sel; // seq_function_select
	logic [1:0] tab_en; // per-table enable
	logic [1:0] edge_en; // edge_detect_enable
	logic [1:0] clk_sel; // table_clock_select
	logic [1:0] out_en; // pin override
	logic [1:0] filt_sel [glue_logic_pkg::NUM_TABLES];
	logic [3:0] sel0 [glue_logic_pkg::NUM_TABLES];
	logic [3:0] sel1 [glue_logic_pkg::NUM_TABLES];
	logic [3:0] sel2 [glue_logic_pkg::NUM_TABLES];
	logic [7:0] truth_register [glue_logic_pkg::NUM_TABLES];

	// ************************************************************
	// datapath state
	// ************************************************************
	logic [5:0] pin_meta; // first synchroniser stage
	logic [5:0] pin_sync;
	logic [1:0] ev_meta; // first synchroniser stage
	logic [1:0] ev_sync;
	logic [3:0] shift [glue_logic_pkg::NUM_TABLES]; // filter chain
	logic [1:0] filt_q; // filter decision
	logic [1:0] edge_prev; // edge detector history
	logic [1:0] src2_prev; // input 2 history for clock edges
	logic seq_q; // sequential element output
	wire [1:0] run; // table live
	wire [1:0] lut_val; // direct truth output
	wire [1:0] src2_raw; // unmasked input 2 source
	wire [1:0] tick; // table clock event
	wire [1:0] filt_out;
	wire [1:0] stage; // after filter and edge detector
	wire [1:0] fin; // final table value
	wire [2:0] in_vec [glue_logic_pkg::NUM_TABLES];

	// ************************************************************
	// helper functions
	// ************************************************************
	// source mux, shared by all six inputs
	function automatic logic pick_source(input logic [3:0] sel,
			input logic fb, input logic link, input logic pin,
			input logic ev_a, input logic ev_b, input logic cmp,
			input logic tmr);
		logic v;
		v = 1'b0; // masked and reserved codes read low
		case (sel)
			glue_logic_pkg::SRC_FEEDBACK: v = fb;
			glue_logic_pkg::SRC_LINK: v = link;
			glue_logic_pkg::SRC_EVENT_A: v = ev_a;
			glue_logic_pkg::SRC_EVENT_B: v = ev_b;
			glue_logic_pkg::SRC_PIN: v = pin;
			glue_logic_pkg::SRC_COMPARATOR: v = cmp;
			glue_logic_pkg::SRC_TIMER: v = tmr;
			default: v = 1'b0;
		endcase
		return v;
	endfunction : pick_source

	// address decode, used for read, write and error answer
	function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
		logic [5:0] idx;
		logic [5:0] rel;
		logic [4:0] d;
		idx = a[7:2];
		rel = idx - glue_logic_pkg::IDX_TABLE_BASE;
		d = 5'h00;
		if (a[1:0] != 2'h0 || (a >> 8) != '0) begin
			d = 5'h00; // misaligned or out of range
		end else if (idx == glue_logic_pkg::IDX_GLOBAL) begin
			d = 5'h10;
		end else if (idx == glue_logic_pkg::IDX_SEQ) begin
			d = 5'h11;
		end else if (idx >= glue_logic_pkg::IDX_TABLE_BASE &&
				rel < 6'(glue_logic_pkg::IDX_TABLE_STRIDE *
				glue_logic_pkg::NUM_TABLES)) begin
			d = {2'h3, rel[2], rel[1:0]};
		end
		return d;
	endfunction : decode

	// ************************************************************
	// apb slave: one wait state, write lands when pready is high
	// ************************************************************
	wire access = psel & penable;
	wire wr_fire = access & pready & pwrite;
	wire [4:0] dec = decode(paddr);
	wire dec_tnum = dec[glue_logic_pkg::DEC_TNUM];
	logic [31:0] rd_word;

	// read mux, reserved bits read zero
	always_comb begin
		rd_word = '0;
		if (dec[glue_logic_pkg::DEC_TABLE]) begin
			case (dec[1:0])
				glue_logic_pkg::OFS_CTRL_A: begin
					rd_word[glue_logic_pkg::BIT_EDGE] = edge_en[dec_tnum];
					rd_word[glue_logic_pkg::BIT_CLK_SEL] = clk_sel[dec_tnum];
					rd_word[glue_logic_pkg::BIT_FILT_LO +:
						glue_logic_pkg::FILT_W] = filt_sel[dec_tnum];
					rd_word[glue_logic_pkg::BIT_OUT_EN] = out_en[dec_tnum];
					rd_word[glue_logic_pkg::BIT_ENABLE] = tab_en[dec_tnum];
				end
				glue_logic_pkg::OFS_CTRL_B: begin
					rd_word[glue_logic_pkg::BIT_SEL0_LO +:
						glue_logic_pkg::SEL_W] = sel0[dec_tnum];
					rd_word[glue_logic_pkg::BIT_SEL1_LO +:
						glue_logic_pkg::SEL_W] = sel1[dec_tnum];
				end
				glue_logic_pkg::OFS_CTRL_C: begin
					rd_word[glue_logic_pkg::BIT_SEL2_LO +:
						glue_logic_pkg::SEL_W] = sel2[dec_tnum];
				end
				default: begin
					rd_word[glue_logic_pkg::TRUTH_W-1:0] =
						truth_register[dec_tnum];
				end
			endcase
		end else if (dec[glue_logic_pkg::DEC_VALID]) begin
			if (dec[0]) begin
				rd_word[glue_logic_pkg::SEQ_W-1:0] = seq_sel;
			end else begin
				rd_word[glue_logic_pkg::BIT_STANDBY] = run_in_standby;
				rd_word[glue_logic_pkg::BIT_ENABLE] = global_en;
			end
		end
	end

	// bus answer, registered so every output leaves a flop
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= access & ~pready;
			if (access & ~pready) begin
				prdata <= pwrite ? '0 : rd_word;
				pslverr <= ~dec[glue_logic_pkg::DEC_VALID];
			end
		end
	end

	// register writes with enable protection
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			global_en <= 1'b0;
			run_in_standby <= 1'b0;
			seq_sel <= glue_logic_pkg::SEQ_OFF;
			tab_en <= '0;
			edge_en <= '0;
			clk_sel <= '0;
			out_en <= '0;
			for (int n = 0; n < glue_logic_pkg::NUM_TABLES; n++) begin
				filt_sel[n] <= glue_logic_pkg::FILT_NONE;
				sel0[n] <= glue_logic_pkg::SRC_MASK;
				sel1[n] <= glue_logic_pkg::SRC_MASK;
				sel2[n] <= glue_logic_pkg::SRC_MASK;
				truth_register[n] <= glue_logic_pkg::RESET_BYTE;
			end
		end else if (wr_fire && dec == 5'h10) begin
			global_en <= pwdata[glue_logic_pkg::BIT_ENABLE];
			run_in_standby <= pwdata[glue_logic_pkg::BIT_STANDBY];
		end else if (wr_fire && dec == 5'h11) begin
			// locked while the even table's enable bit is set
			if (!tab_en[0]) begin
				seq_sel <= pwdata[glue_logic_pkg::SEQ_W-1:0];
			end
		end else if (wr_fire && dec[glue_logic_pkg::DEC_TABLE]) begin
			case (dec[1:0])
				glue_logic_pkg::OFS_CTRL_A: begin
					tab_en[dec_tnum] <= pwdata[glue_logic_pkg::BIT_ENABLE];
					// old enable decides: while enabled, only the enable bit is written
					if (!tab_en[dec_tnum]) begin
						edge_en[dec_tnum] <= pwdata[glue_logic_pkg::BIT_EDGE];
						clk_sel[dec_tnum] <= pwdata[glue_logic_pkg::BIT_CLK_SEL];
						out_en[dec_tnum] <= pwdata[glue_logic_pkg::BIT_OUT_EN];
						filt_sel[dec_tnum] <= pwdata[glue_logic_pkg::BIT_FILT_LO +:
							glue_logic_pkg::FILT_W];
					end
				end
				glue_logic_pkg::OFS_CTRL_B: begin
					if (!tab_en[dec_tnum]) begin
						sel0[dec_tnum] <= pwdata[glue_logic_pkg::BIT_SEL0_LO +:
							glue_logic_pkg::SEL_W];
						sel1[dec_tnum] <= pwdata[glue_logic_pkg::BIT_SEL1_LO +:
							glue_logic_pkg::SEL_W];
					end
				end
				glue_logic_pkg::OFS_CTRL_C: begin
					if (!tab_en[dec_tnum]) begin
						sel2[dec_tnum] <= pwdata[glue_logic_pkg::BIT_SEL2_LO +:
							glue_logic_pkg::SEL_W];
					end
				end
				default: begin
					truth_register[dec_tnum] <=
						pwdata[glue_logic_pkg::TRUTH_W-1:0];
				end
			endcase
		end
	end

	// ************************************************************
	// input synchronisers: pins and events are asynchronous
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_meta <= '0;
			pin_sync <= '0;
			ev_meta <= '0;
			ev_sync <= '0;
		end else begin
			pin_meta <= table_pin_in;
			pin_sync <= pin_meta;
			ev_meta <= {event_input_b, event_input_a};
			ev_sync <= ev_meta;
		end
	end

	// ************************************************************
	// per-table truth lookup, clocking, filter, edge detector
	// ************************************************************
	for (genvar gn = 0; gn < glue_logic_pkg::NUM_TABLES; gn++) begin : g_tab
		wire link_val;
		// last table has no successor, so link reads low
		if (gn + 1 < glue_logic_pkg::NUM_TABLES) begin : g_link
			assign link_val = lut_val[gn+1];
		end else begin : g_nolink
			assign link_val = 1'b0;
		end
		assign src2_raw[gn] = pick_source(sel2[gn], seq_q, link_val,
			pin_sync[gn*3+2], ev_sync[0], ev_sync[1], comparator_out,
			timer_wave[2]);
		assign in_vec[gn][0] = pick_source(sel0[gn], seq_q, link_val,
			pin_sync[gn*3], ev_sync[0], ev_sync[1], comparator_out,
			timer_wave[0]);
		assign in_vec[gn][1] = pick_source(sel1[gn], seq_q, link_val,
			pin_sync[gn*3+1], ev_sync[0], ev_sync[1], comparator_out,
			timer_wave[1]);
		// input 2 used as clock reads as masked
		assign in_vec[gn][2] = clk_sel[gn] ? 1'b0 : src2_raw[gn];
		assign lut_val[gn] = truth_register[gn][in_vec[gn]];
		assign run[gn] = global_en & tab_en[gn];
		// input 2 clock is sampled, so it must be slower than ref_clk
		assign tick[gn] = clk_sel[gn] ?
			(src2_raw[gn] & ~src2_prev[gn]) : 1'b1;
		assign filt_out[gn] =
			(filt_sel[gn] == glue_logic_pkg::FILT_SYNC) ?
			shift[gn][glue_logic_pkg::SYNC_TAP] :
			(filt_sel[gn] == glue_logic_pkg::FILT_FILTER) ?
			filt_q[gn] : lut_val[gn];
		assign stage[gn] = edge_en[gn] ?
			(filt_out[gn] & ~edge_prev[gn]) : filt_out[gn];

		// filter chain and edge history, cleared once table drops
		always_ff @(posedge ref_clk) begin
			if (rst || !run[gn]) begin
				shift[gn] <= '0;
				filt_q[gn] <= 1'b0;
				edge_prev[gn] <= 1'b0;
			end else if (tick[gn]) begin
				shift[gn] <= {shift[gn][glue_logic_pkg::SHIFT_STAGES-2:0],
					lut_val[gn]};
				// filter moves only on three agreeing samples
				if (&shift[gn][glue_logic_pkg::SHIFT_STAGES-1:
						glue_logic_pkg::SYNC_TAP] ||
						~|shift[gn][glue_logic_pkg::SHIFT_STAGES-1:
						glue_logic_pkg::SYNC_TAP]) begin
					filt_q[gn] <= shift[gn][glue_logic_pkg::SHIFT_STAGES-1];
				end
				edge_prev[gn] <= filt_out[gn];
			end
		end

		// history of input 2 for clock edge detection
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				src2_prev[gn] <= 1'b0;
			end else begin
				src2_prev[gn] <= src2_raw[gn];
			end
		end
	end

	// ************************************************************
	// sequential element of the pair
	// ************************************************************
	// even table supplies data/j/set, odd table gate/k/reset
	always_ff @(posedge ref_clk) begin
		if (rst || !run[0]) begin
			seq_q <= 1'b0;
		end else begin
			case (seq_sel)
				glue_logic_pkg::SEQ_GATED_FF: begin
					if (tick[0] && stage[1]) begin
						seq_q <= stage[0];
					end
				end
				glue_logic_pkg::SEQ_JK: begin
					if (tick[0]) begin
						case ({stage[0], stage[1]})
							2'h1: seq_q <= 1'b0;
							2'h2: seq_q <= 1'b1;
							2'h3: seq_q <= ~seq_q;
							default: seq_q <= seq_q;
						endcase
					end
				end
				glue_logic_pkg::SEQ_GATED_LATCH: begin
					if (stage[1]) begin
						seq_q <= stage[0];
					end
				end
				glue_logic_pkg::SEQ_RS: begin
					// both high is forbidden; it simply holds here
					if (stage[0] && !stage[1]) begin
						seq_q <= 1'b1;
					end else if (stage[1] && !stage[0]) begin
						seq_q <= 1'b0;
					end
				end
				default: seq_q <= seq_q;
			endcase
		end
	end

	// with a function chosen, the even table shows the element
	assign fin[0] = (seq_sel == glue_logic_pkg::SEQ_GATED_FF ||
		seq_sel == glue_logic_pkg::SEQ_JK ||
		seq_sel == glue_logic_pkg::SEQ_GATED_LATCH ||
		seq_sel == glue_logic_pkg::SEQ_RS) ? seq_q : stage[0];
	assign fin[1] = stage[1];

	// ************************************************************
	// registered outputs
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			table_output <= '0;
			table_output_event <= '0;
			table_pin_out <= '0;
			table_pin_drive <= '0;
		end else begin
			table_output <= run & fin;
			table_output_event <= run & fin;
			table_pin_out <= run & out_en & fin;
			table_pin_drive <= run & out_en;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_seq_protect;
		wr_fire && dec == 5'h11 && tab_en[0] |=> seq_sel == $past(seq_sel);
	endproperty
	a_seq_protect: assert property (p_seq_protect)
		else $error("sequential select changed while locked");

	property p_ctrl_protect;
		wr_fire && dec == 5'h19 && tab_en[0] |=> sel0[0] == $past(sel0[0]);
	endproperty
	a_ctrl_protect: assert property (p_ctrl_protect)
		else $error("input select changed while table enabled");

	property p_enable_accept;
		wr_fire && dec == 5'h18 && !tab_en[0] && pwdata[0] |=>
			tab_en[0] && filt_sel[0] == $past(pwdata[5:4]);
	endproperty
	a_enable_accept: assert property (p_enable_accept)
		else $error("enabling write lost the filter field");

	property p_global;
		wr_fire && dec == 5'h10 |=> global_en == $past(pwdata[0]);
	endproperty
	a_global: assert property (p_global)
		else $error("global enable not written");

	property p_mask_truth;
		sel0[0] == glue_logic_pkg::SRC_MASK &&
		sel1[0] == glue_logic_pkg::SRC_MASK &&
		sel2[0] == glue_logic_pkg::SRC_MASK |->
			lut_val[0] == truth_register[0][0];
	endproperty
	a_mask_truth: assert property (p_mask_truth)
		else $error("masked inputs did not pick truth bit zero");

	property p_feedback;
		sel0[1] == glue_logic_pkg::SRC_FEEDBACK |-> in_vec[1][0] == seq_q;
	endproperty
	a_feedback: assert property (p_feedback)
		else $error("feedback input does not carry element output");

	property p_link;
		sel1[0] == glue_logic_pkg::SRC_LINK |-> in_vec[0][1] == lut_val[1];
	endproperty
	a_link: assert property (p_link)
		else $error("linked input does not carry odd table output");

	property p_filter_clear;
		!run[0] |=> shift[0] == '0 && !filt_q[0] && !edge_prev[0];
	endproperty
	a_filter_clear: assert property (p_filter_clear)
		else $error("filter state not cleared after disable");

	property p_seq_clear;
		!run[0] |=> !seq_q && !table_output[0];
	endproperty
	a_seq_clear: assert property (p_seq_clear)
		else $error("element not cleared by even table disable");

	property p_jk_toggle;
		run[0] && seq_sel == glue_logic_pkg::SEQ_JK && tick[0] &&
			stage[0] && stage[1] |=> seq_q != $past(seq_q);
	endproperty
	a_jk_toggle: assert property (p_jk_toggle)
		else $error("jk element did not toggle");

	property p_latch_follow;
		run[0] && seq_sel == glue_logic_pkg::SEQ_GATED_LATCH && stage[1]
			|=> seq_q == $past(stage[0]);
	endproperty
	a_latch_follow: assert property (p_latch_follow)
		else $error("latch did not follow data");

	property p_clk_mask;
		clk_sel[1] |-> !in_vec[1][2];
	endproperty
	a_clk_mask: assert property (p_clk_mask)
		else $error("clock input not masked in truth lookup");

	property p_off_low;
		!global_en ##1 !global_en |-> table_output == '0 &&
			table_output_event == '0 && table_pin_out == '0;
	endproperty
	a_off_low: assert property (p_off_low)
		else $error("output high while unit off");

	c_toggle: cover property (run[0] && seq_sel == glue_logic_pkg::SEQ_JK
		&& tick[0] && stage[0] && stage[1]);
	c_edge: cover property (run[1] && edge_en[1] && stage[1]);
	c_clocked: cover property (run[0] && clk_sel[0] && tick[0]);
	c_error: cover property (pready && pslverr);
endmodule : glue_logic_unit

// ### verilog/glue_logic_pkg.sv
// constants and encodings shared by the glue logic unit
package glue_logic_pkg;
	// ************************************************************
	// sizes
	// ************************************************************
	localparam int NUM_TABLES = 2; // one even/odd pair
	localparam int APB_ADDR_W = 8;
	localparam int APB_DATA_W = 32;
	localparam int SEL_W = 4; // input source field width
	localparam int FILT_W = 2; // filter field width
	localparam int SEQ_W = 4; // sequential field width
	localparam int TRUTH_W = 8; // truth register width
	localparam int SHIFT_STAGES = 4; // filter shift chain length
	localparam int SYNC_TAP = 1; // synchronizer tap in the chain

	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [5:0] IDX_GLOBAL = 6'h00;
	localparam logic [5:0] IDX_SEQ = 6'h01;
	localparam logic [5:0] IDX_TABLE_BASE = 6'h05;
	localparam logic [5:0] IDX_TABLE_STRIDE = 6'h04;
	localparam logic [1:0] OFS_CTRL_A = 2'h0;
	localparam logic [1:0] OFS_CTRL_B = 2'h1;
	localparam logic [1:0] OFS_CTRL_C = 2'h2;
	localparam logic [1:0] OFS_TRUTH = 2'h3;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_ENABLE = 0; // global and table enable
	localparam int BIT_STANDBY = 6; // run_in_standby, global reg
	localparam int BIT_OUT_EN = 3;
	localparam int BIT_FILT_LO = 4;
	localparam int BIT_CLK_SEL = 6;
	localparam int BIT_EDGE = 7;
	localparam int BIT_SEL0_LO = 0;
	localparam int BIT_SEL1_LO = 4;
	localparam int BIT_SEL2_LO = 0;
	// decode result layout
	localparam int DEC_VALID = 4;
	localparam int DEC_TABLE = 3;
	localparam int DEC_TNUM = 2;

	// ************************************************************
	// encodings
	// ************************************************************
	localparam logic [3:0] SEQ_OFF = 4'h0;
	localparam logic [3:0] SEQ_GATED_FF = 4'h1;
	localparam logic [3:0] SEQ_JK = 4'h2;
	localparam logic [3:0] SEQ_GATED_LATCH = 4'h3;
	localparam logic [3:0] SEQ_RS = 4'h4;
	localparam logic [1:0] FILT_NONE = 2'h0;
	localparam logic [1:0] FILT_SYNC = 2'h1;
	localparam logic [1:0] FILT_FILTER = 2'h2;
	localparam logic [3:0] SRC_MASK = 4'h0;
	localparam logic [3:0] SRC_FEEDBACK = 4'h1;
	localparam logic [3:0] SRC_LINK = 4'h2;
	localparam logic [3:0] SRC_EVENT_A = 4'h3;
	localparam logic [3:0] SRC_EVENT_B = 4'h4;
	localparam logic [3:0] SRC_PIN = 4'h5;
	localparam logic [3:0] SRC_COMPARATOR = 4'h6;
	localparam logic [3:0] SRC_TIMER = 4'h7;
endpackage : glue_logic_pkg

// ### test/glue_peer.sv
// far-side model: pins, event lines, comparator and timer waveforms
`timescale 1ns/100ps
module glue_peer (
	// clock
	input wire logic ref_clk,
	// levels that the bench asks the far side to present
	input wire logic [11:0] stim,
	// sources seen by the glue logic unit
	output logic [5:0] table_pin_in,
	output logic event_input_a,
	output logic event_input_b,
	output logic comparator_out,
	output logic [2:0] timer_wave
);
	// ************************************************************
	// sources move just after an edge, as on-chip peripherals do
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		table_pin_in <= stim[5:0]; // pin levels
		event_input_a <= stim[6];
		event_input_b <= stim[7];
		comparator_out <= stim[8]; // comparator level
		timer_wave <= stim[11:9]; // one waveform per input line
	end
endmodule : glue_peer

// ### test/test_glue_logic_unit.sv
// self-checking bench for the glue logic unit
`timescale 1ns/100ps
module test_glue_logic_unit;
	// ************************************************************
	// signals
	// ************************************************************
	logic ref_clk = 1'b0; // bench clock
	logic rst = 1'b1; // held for three cycles
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd; // read data, last taken value
	logic pready, pslverr, er;
	logic [11:0] stim = 12'h000; // far-side levels
	logic [5:0] pins;
	logic ev_a, ev_b, cmp;
	logic [2:0] tmr;
	logic [1:0] t_out, t_evt, p_out, p_drv;
	logic [7:0] truth; // random truth value
	int failures = 0, num_checks = 0, cyc = 0;

	always #10 ref_clk = ~ref_clk; // 50 MHz

	glue_peer glue_peer_i (.ref_clk(ref_clk), .stim(stim),
		.table_pin_in(pins), .event_input_a(ev_a), .event_input_b(ev_b),
		.comparator_out(cmp), .timer_wave(tmr));
	glue_logic_unit glue_logic_unit_i (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .table_pin_in(pins), .event_input_a(ev_a),
		.event_input_b(ev_b), .comparator_out(cmp), .timer_wave(tmr),
		.table_output(t_out), .table_output_event(t_evt),
		.table_pin_out(p_out), .table_pin_drive(p_drv));

	// ************************************************************
	// tasks
	// ************************************************************
	// one apb transfer; waits for pready, bounded by the timeout
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// expected table value: truth bit picked by {in2,in1,in0}
	function automatic logic [31:0] exp_bit(input logic [7:0] t,
			input logic [2:0] i);
		return {31'h0, t[i]};
	endfunction : exp_bit
	// report and stop
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim

	// hang guard, far above the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		void'($urandom(62));
		truth = 8'($urandom);
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h08, 32'h0000_0000); // reserved index
		chk({31'h0, er}, 32'h0000_0001);
		apb(1'b1, 8'h00, 32'h0000_0001); // global on
		apb(1'b1, 8'h18, 32'h0000_0076);
		apb(1'b1, 8'h1C, 32'h0000_0007); // input 2 from timer
		apb(1'b1, 8'h20, {24'h0, truth});
		apb(1'b1, 8'h14, 32'h0000_0001); // table 0 on, no filter
		apb(1'b1, 8'h04, 32'h0000_0002); // locked while table 0 on
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b1, 8'h18, 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk(rd, 32'h0000_0076);
		// walk every input combination in ascending order
		for (int k = 0; k < 8; k++) begin
			@(posedge ref_clk);
			stim <= {k[2], k[1], 1'b0, k[0], 8'h00};
			repeat (4) @(posedge ref_clk);
			chk({31'h0, t_out[0]}, exp_bit(truth, k[2:0]));
			chk({31'h0, t_evt[0]}, exp_bit(truth, k[2:0]));
		end
		apb(1'b1, 8'h00, 32'h0000_0000); // global off
		repeat (2) @(posedge ref_clk);
		chk({30'h0, t_out}, 32'h0000_0000);
		apb(1'b1, 8'h14, 32'h0000_0030); // disabling write
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b1, 8'h14, 32'h0000_0011); // enabling write
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk(rd, 32'h0000_0011);
		// jk element: table 0 drives j, table 1 drives k
		apb(1'b1, 8'h14, 32'h0000_0000); // table 0 off
		apb(1'b1, 8'h04, 32'h0000_0002);
		apb(1'b1, 8'h20, 32'h0000_00FF); // j high
		apb(1'b1, 8'h30, 32'h0000_0000); // k low
		apb(1'b1, 8'h14, 32'h0000_0009); // enable with pin out
		apb(1'b1, 8'h00, 32'h0000_0001);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, t_out[0]}, 32'h0000_0001);
		chk({28'h0, p_drv, p_out}, 32'h0000_0005);
		apb(1'b1, 8'h20, 32'h0000_0000); // j low, element holds
		repeat (3) @(posedge ref_clk);
		chk({31'h0, t_out[0]}, 32'h0000_0001);
		apb(1'b1, 8'h30, 32'h0000_00FF); // k high, element clears
		repeat (3) @(posedge ref_clk);
		chk({31'h0, t_out[0]}, 32'h0000_0000);
		// clock select is changed only while the unit is off
		apb(1'b1, 8'h00, 32'h0000_0000);
		apb(1'b1, 8'h14, 32'h0000_0000);
		apb(1'b1, 8'h04, 32'h0000_0000); // combinational again
		apb(1'b1, 8'h20, 32'h0000_0004); // only index 2 high
		apb(1'b1, 8'h14, 32'h0000_0049); // input 2 as table clock
		stim <= 12'hE00; // input 2 high, but masked in the lookup
		apb(1'b1, 8'h00, 32'h0000_0001);
		repeat (4) @(posedge ref_clk);
		chk({31'h0, t_out[0]}, exp_bit(8'h04, 3'h2));
		end_sim();
	end
endmodule : test_glue_logic_unit
